// File: design/itrp_target.sv
`timescale 1ns/1ps

// Overview of operation
// - Idle bus: both lines released high
// - Start detected in every state
// - Stop returns block to idle
// - Repeated start restarts address reception
// - Ignore clocks after stop or mismatch
// - Ninth clock: receiver drives data low
// - Not-acknowledge leaves data line released
// - Bytes shifted most significant bit first
// - Multibyte values least significant byte lowest
// - Strap picks one of four addresses
// - Refuse every other address byte
// - Test address answered only when unlocked
// - Clock line never held low
// - General call never acknowledged
// - Works any rate up to 1MHz
// - Normal filters at power-up, after stop
// - Write: address, pointer, data acknowledged
// - Data loads at acknowledge rising clock
// - Every further write byte acknowledged
// - Read returns bytes from pointed register
// - Data line driven only low, open-drain
// - Data stable while clock high
module itrp_target (
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic [1:0]        addr_sel,
  input  wire logic              test_unlock,
  input  wire logic              scl_i,
  output logic                   scl_o,
  output logic                   scl_oe_n,
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe_n,
  output itrp_pkg::itrp_wr_s     wr_q,
  output logic [7:0]             rd_addr_q,
  input  wire logic [7:0]        rd_data,
  output logic                   filt_sel_q,
  output logic                   busy_q
);

  function automatic logic [6:0] main_addr(input logic [1:0] sel);
    unique case (sel)
      itrp_pkg::ADDR_SEL_0: main_addr = itrp_pkg::MAIN_ADDR_0;
      itrp_pkg::ADDR_SEL_1: main_addr = itrp_pkg::MAIN_ADDR_1;
      itrp_pkg::ADDR_SEL_2: main_addr = itrp_pkg::MAIN_ADDR_2;
      itrp_pkg::ADDR_SEL_3: main_addr = itrp_pkg::MAIN_ADDR_3;
    endcase
  endfunction : main_addr

  // Two-stage synchronisers; pin edges only seen from second stage
  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic       scl_prev_q;
  logic       sda_prev_q;
  logic [1:0] sel_sync1_q;
  logic [1:0] sel_sync2_q;
  logic [1:0] unl_sync_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      scl_sync_q  <= 2'h3;
      sda_sync_q  <= 2'h3;
      scl_prev_q  <= 1'b1;
      sda_prev_q  <= 1'b1;
      sel_sync1_q <= 2'h0;
      sel_sync2_q <= 2'h0;
      unl_sync_q  <= 2'h0;
    end else begin
      scl_sync_q  <= {scl_sync_q[0], scl_i};
      sda_sync_q  <= {sda_sync_q[0], sda_i};
      scl_prev_q  <= scl_sync_q[1];
      sda_prev_q  <= sda_sync_q[1];
      sel_sync1_q <= addr_sel;
      sel_sync2_q <= sel_sync1_q;
      unl_sync_q  <= {unl_sync_q[0], test_unlock};
    end
  end

  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  // Conditions are sampled on the synchronised lines only
  assign scl_s     = scl_sync_q[1];
  assign sda_s     = sda_sync_q[1];
  assign scl_rise  = scl_s & ~scl_prev_q;
  assign scl_fall  = ~scl_s & scl_prev_q;
  assign start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  assign stop_det  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

  itrp_pkg::itrp_state_e state_q;
  logic [3:0]            bit_cnt_q;
  logic [7:0]            shift_q;
  logic [7:0]            ptr_q;
  logic                  ack_phase_q;
  logic                  drive_low_q;
  logic                  rd_dir_q;
  logic                  master_nack_q;

  logic       addr_hit;
  logic       byte_done;

  // Compared only after the eighth bit lands; shift_q then holds addr[6:0] in [7:1]
  assign byte_done = scl_fall & ~ack_phase_q & (bit_cnt_q == itrp_pkg::BITS_PER_BYTE);
  assign addr_hit  = (shift_q[7:1] != itrp_pkg::GCALL_ADDR) &
                     ((shift_q[7:1] == main_addr(sel_sync2_q)) |
                      (unl_sync_q[1] & (shift_q[7:1] == itrp_pkg::TEST_ADDR)));

  // Bit sampling on rising clock, MSB first
  always_ff @(posedge clk) begin
    if (srst) begin
      shift_q   <= itrp_pkg::BYTE_RST;
      bit_cnt_q <= itrp_pkg::BIT_CNT_RST;
    end else if (start_det) begin
      bit_cnt_q <= itrp_pkg::BIT_CNT_RST;
    end else if (state_q == itrp_pkg::ST_RDATA) begin
      // Transmit path shifts on falling edge, new bit set up for next high phase
      if (scl_fall) begin
        if (bit_cnt_q == itrp_pkg::BITS_PER_BYTE - 4'h1) begin
          bit_cnt_q <= itrp_pkg::BIT_CNT_RST;
        end else begin
          shift_q   <= {shift_q[6:0], 1'b0};
          bit_cnt_q <= bit_cnt_q + 4'h1;
        end
      end
    end else if (state_q == itrp_pkg::ST_RACK) begin
      // Next byte loaded as the controller's acknowledge ends
      if (scl_fall) begin
        shift_q   <= rd_data;
        bit_cnt_q <= itrp_pkg::BIT_CNT_RST;
      end
    end else if (state_q != itrp_pkg::ST_IDLE && scl_rise && !ack_phase_q) begin
      shift_q   <= {shift_q[6:0], sda_s};
      bit_cnt_q <= bit_cnt_q + 4'h1;
    end else if (ack_phase_q && scl_fall) begin
      bit_cnt_q <= itrp_pkg::BIT_CNT_RST;
      if (state_q == itrp_pkg::ST_ADDR && rd_dir_q) begin
        shift_q <= rd_data;
      end
    end else if (byte_done) begin
      bit_cnt_q <= itrp_pkg::BIT_CNT_RST;
    end
  end

  // Protocol state: start anywhere, stop to idle, mismatch parks in idle
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q       <= itrp_pkg::ST_IDLE;
      ack_phase_q   <= 1'b0;
      drive_low_q   <= 1'b0;
      rd_dir_q      <= 1'b0;
      master_nack_q <= 1'b0;
    end else if (start_det) begin
      state_q     <= itrp_pkg::ST_ADDR;
      ack_phase_q <= 1'b0;
      drive_low_q <= 1'b0;
    end else if (stop_det) begin
      state_q     <= itrp_pkg::ST_IDLE;
      ack_phase_q <= 1'b0;
      drive_low_q <= 1'b0;
    end else begin
      unique case (state_q)
        itrp_pkg::ST_IDLE: begin
          drive_low_q <= 1'b0;
        end
        itrp_pkg::ST_ADDR: begin
          if (byte_done) begin
            if (addr_hit) begin
              ack_phase_q <= 1'b1;
              drive_low_q <= 1'b1;
              rd_dir_q    <= shift_q[0];
            end else begin
              state_q <= itrp_pkg::ST_IDLE;
            end
          end else if (ack_phase_q && scl_fall) begin
            ack_phase_q <= 1'b0;
            if (rd_dir_q) begin
              state_q     <= itrp_pkg::ST_RDATA;
              drive_low_q <= ~rd_data[7];
            end else begin
              state_q     <= itrp_pkg::ST_PTR;
              drive_low_q <= 1'b0;
            end
          end
        end
        itrp_pkg::ST_PTR, itrp_pkg::ST_WDATA: begin
          if (byte_done) begin
            ack_phase_q <= 1'b1;
            drive_low_q <= 1'b1;
          end else if (ack_phase_q && scl_fall) begin
            ack_phase_q <= 1'b0;
            drive_low_q <= 1'b0;
            state_q     <= itrp_pkg::ST_WDATA;
          end
        end
        itrp_pkg::ST_RDATA: begin
          if (scl_fall) begin
            if (bit_cnt_q == itrp_pkg::BITS_PER_BYTE - 4'h1) begin
              state_q     <= itrp_pkg::ST_RACK;
              drive_low_q <= 1'b0; // controller answers
            end else begin
              drive_low_q <= ~shift_q[6];
            end
          end
        end
        itrp_pkg::ST_RACK: begin
          if (scl_rise) begin
            master_nack_q <= sda_s;
          end else if (scl_fall) begin
            if (master_nack_q) begin
              state_q <= itrp_pkg::ST_IDLE; // wait for stop or start
            end else begin
              state_q     <= itrp_pkg::ST_RDATA;
              drive_low_q <= ~rd_data[7];
            end
          end
        end
      endcase
    end
  end

  // Pointer load and write strobe at the ack-pulse rising clock
  always_ff @(posedge clk) begin
    if (srst) begin
      ptr_q <= itrp_pkg::PTR_RST;
      wr_q  <= '0;
    end else begin
      wr_q.valid <= 1'b0;
      if (ack_phase_q && scl_rise && state_q == itrp_pkg::ST_PTR) begin
        ptr_q <= shift_q;
      end else if (ack_phase_q && scl_rise && state_q == itrp_pkg::ST_WDATA) begin
        wr_q.valid <= 1'b1;
        wr_q.addr  <= ptr_q;
        wr_q.data  <= shift_q;
        ptr_q      <= ptr_q + 8'h01;
      end else if (state_q == itrp_pkg::ST_RACK && scl_fall) begin
        ptr_q <= ptr_q + 8'h01;
      end
    end
  end

  // Read address tracks the pointer so data is ready before each byte
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_addr_q <= itrp_pkg::PTR_RST;
    end else if (state_q == itrp_pkg::ST_RACK || (state_q == itrp_pkg::ST_ADDR && ack_phase_q)) begin
      rd_addr_q <= (state_q == itrp_pkg::ST_RACK) ? ptr_q + 8'h01 : ptr_q;
    end else begin
      rd_addr_q <= ptr_q;
    end
  end

  // Filter choice: normal at reset and stop, untouched by repeated start
  always_ff @(posedge clk) begin
    if (srst) begin
      filt_sel_q <= itrp_pkg::FILT_NORMAL;
    end else if (stop_det) begin
      filt_sel_q <= itrp_pkg::FILT_NORMAL;
    end
  end

  // Open-drain pins: data driven low only, clock never driven
  always_ff @(posedge clk) begin
    if (srst) begin
      sda_o    <= 1'b1;
      sda_oe_n <= 1'b1;
      scl_o    <= 1'b1;
      scl_oe_n <= 1'b1;
      busy_q   <= 1'b0;
    end else begin
      sda_o    <= 1'b0;
      sda_oe_n <= ~drive_low_q;
      scl_o    <= 1'b0;
      scl_oe_n <= 1'b1;
      busy_q   <= (state_q != itrp_pkg::ST_IDLE);
    end
  end

endmodule : itrp_target

// File: design/itrp_pkg.sv
package itrp_pkg;

  // Address selection strap values
  localparam logic [1:0] ADDR_SEL_0   = 2'h0;
  localparam logic [1:0] ADDR_SEL_1   = 2'h1;
  localparam logic [1:0] ADDR_SEL_2   = 2'h2;
  localparam logic [1:0] ADDR_SEL_3   = 2'h3;

  // Seven-bit target addresses
  localparam logic [6:0] MAIN_ADDR_0  = 7'h41;
  localparam logic [6:0] MAIN_ADDR_1  = 7'h42;
  localparam logic [6:0] MAIN_ADDR_2  = 7'h6a;
  localparam logic [6:0] MAIN_ADDR_3  = 7'h6b;
  localparam logic [6:0] TEST_ADDR    = 7'h49;
  localparam logic [6:0] GCALL_ADDR   = 7'h00;

  // Byte framing
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] BIT_CNT_RST   = 4'h0;
  localparam logic [7:0] PTR_RST       = 8'h00;
  localparam logic [7:0] BYTE_RST      = 8'h00;

  // Filter selection codes
  localparam logic       FILT_NORMAL  = 1'b0;
  localparam logic       FILT_HS      = 1'b1;

  // Register write strobe to the register map
  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
    logic [7:0] data;
  } itrp_wr_s;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_PTR,
    ST_WDATA,
    ST_RDATA,
    ST_RACK
  } itrp_state_e;

endpackage : itrp_pkg

// File: test/itrp_ctl_model.sv
`timescale 1ns/1ps

// Bus controller; an output of 1 means released
module itrp_ctl_model (
  output logic      scl,
  output logic      sda,
  input  wire logic sda_ln
);
  // Both lines released while no frame runs
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // Start, also used as repeated start
  task automatic start();
    sda = 1'b1;
    #20 scl = 1'b1;
    #20 sda = 1'b0;
    #20 scl = 1'b0;
    #20;
  endtask : start
  // Stop frees the bus
  task automatic stop();
    sda = 1'b0;
    #20 scl = 1'b1;
    #20 sda = 1'b1;
    #20;
  endtask : stop
  // Nine clocks, MSB first; data moves only while clock is low
  task automatic bits(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      sda = tx[i];
      #20 scl = 1'b1;
      #20 rx[i] = sda_ln;
      #20 scl = 1'b0;
      #20;
    end
  endtask : bits
endmodule : itrp_ctl_model

// File: test/itrp_target_asserts.sv
`timescale 1ns/1ps

module itrp_target_asserts (
  input wire logic               clk,
  input wire logic               srst,
  input wire logic               scl_i,
  input wire logic               scl_oe_n,
  input wire logic               sda_i,
  input wire logic               sda_o,
  input wire logic               sda_oe_n,
  input wire itrp_pkg::itrp_wr_s wr_q,
  input wire logic               filt_sel_q,
  input wire logic               busy_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // Bus conditions as seen on the raw pins
  sequence s_start;
    scl_i && $past(scl_i) && $fell(sda_i);
  endsequence
  sequence s_stop;
    scl_i && $past(scl_i) && $rose(sda_i);
  endsequence
  // Any low drive lasts at least eight clock cycles
  sequence s_held;
    !sda_oe_n [*8];
  endsequence
  chk_scl_free: assert property (scl_oe_n) else $error("clock line pulled");
  chk_sda_od: assert property (!sda_oe_n |-> !sda_o) else $error("data driven high");
  chk_filt_norm: assert property (filt_sel_q == itrp_pkg::FILT_NORMAL) else $error("filter");
  chk_start_busy: assert property (s_start |-> ##[1:8] busy_q) else $error("start missed");
  chk_stop_idle: assert property (s_stop |-> ##[1:8] !busy_q) else $error("stop missed");
  chk_idle_release: assert property (!busy_q |-> sda_oe_n) else $error("drive when idle");
  chk_ack_hold: assert property ($fell(sda_oe_n) |-> s_held) else $error("drive too short");
  chk_wr_pulse: assert property (wr_q.valid |=> !wr_q.valid) else $error("strobe long");
  chk_wr_ack: assert property (wr_q.valid |-> !sda_oe_n && busy_q) else $error("strobe off ack");
endmodule : itrp_target_asserts

bind itrp_target itrp_target_asserts u_itrp_target_asserts (
  .clk(clk), .srst(srst), .scl_i(scl_i), .scl_oe_n(scl_oe_n), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_n(sda_oe_n), .wr_q(wr_q), .filt_sel_q(filt_sel_q), .busy_q(busy_q)
);

// File: test/itrp_target_tb.sv
`timescale 1ns/1ps

module itrp_target_tb;
  logic               clk, srst, test_unlock, scl_c, sda_c, scl_o, scl_oe_n, sda_o, sda_oe_n;
  logic               filt_sel_q, busy_q;
  logic [1:0]         addr_sel;
  logic [7:0]         rd_addr_q, rd_data;
  logic [8:0]         r;
  itrp_pkg::itrp_wr_s wr_q;
  itrp_pkg::itrp_wr_s wq[$];
  int                 n_mismatch, tests_run;
  // Wired-AND with pull-ups
  wire scl_ln = scl_c & (scl_oe_n | scl_o);
  wire sda_ln = sda_c & (sda_oe_n | sda_o);
  function automatic logic [7:0] f(logic [7:0] p);
    return {p[3:0], p[7:4]} ^ 8'hc3;
  endfunction : f
  assign rd_data = f(rd_addr_q);
  itrp_target u_itrp_target (.clk(clk), .srst(srst), .addr_sel(addr_sel), .test_unlock(test_unlock),
    .scl_i(scl_ln), .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda_ln), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .wr_q(wr_q), .rd_addr_q(rd_addr_q), .rd_data(rd_data),
    .filt_sel_q(filt_sel_q), .busy_q(busy_q));
  itrp_ctl_model u_itrp_ctl_model (.scl(scl_c), .sda(sda_c), .sda_ln(sda_ln));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Log every write strobe
  always @(posedge clk) if (wr_q.valid === 1'b1) wq.push_back(wr_q);
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic setin(logic [1:0] s, logic u);
    @(posedge clk);
    #1 addr_sel = s;
    test_unlock = u;
    repeat (4) @(posedge clk);
  endtask : setin
  // Send a byte; a is the expected acknowledge level
  task automatic wb(logic [7:0] b, logic a);
    u_itrp_ctl_model.bits({b, 1'b1}, r);
    chk("ack", r[0], a);
  endtask : wb
  task automatic rb(logic a, logic [7:0] e);
    u_itrp_ctl_model.bits({8'hff, a}, r);
    chk("rdata", r[8:1], e);
  endtask : rb
  task automatic t_write();
    logic [6:0] at[4];
    logic [7:0] p;
    at = '{7'h41, 7'h42, 7'h6a, 7'h6b};
    for (int s = 0; s < 4; s++) begin
      setin(s, 1'b0);
      wq.delete();
      p = 8'h10 * s + 8'h0f;
      u_itrp_ctl_model.start();
      wb({at[(s + 1) % 4], 1'b0}, 1'b1);
      wb(8'h00, 1'b1);
      u_itrp_ctl_model.start();
      wb({at[s], 1'b0}, 1'b0);
      wb(p, 1'b0);
      wb(8'ha5 ^ s, 1'b0);
      wb(8'h3c ^ s, 1'b0);
      u_itrp_ctl_model.stop();
      #200;
      chk("wcount", wq.size(), 2);
      chk("w0", {wq[0].addr, wq[0].data}, {p, 8'ha5 ^ 8'(s)});
      chk("w1", {wq[1].addr, wq[1].data}, {p + 8'h01, 8'h3c ^ 8'(s)});
      chk("busy", busy_q, 1'b0);
    end
    $display("t_write done");
  endtask : t_write
  task automatic t_refuse();
    setin(2'h0, 1'b0);
    wq.delete();
    u_itrp_ctl_model.start();
    wb(8'h00, 1'b1);
    wb(8'h82, 1'b1);
    wb(8'h01, 1'b1);
    u_itrp_ctl_model.stop();
    u_itrp_ctl_model.start();
    wb(8'h92, 1'b1);
    u_itrp_ctl_model.stop();
    u_itrp_ctl_model.start();
    wb(8'h86, 1'b1);
    u_itrp_ctl_model.stop();
    #200;
    chk("nowrite", wq.size(), 0);
    // Unlocked test address, then retry of the main one
    setin(2'h0, 1'b1);
    u_itrp_ctl_model.start();
    wb(8'h92, 1'b0);
    u_itrp_ctl_model.stop();
    u_itrp_ctl_model.start();
    wb(8'h82, 1'b0);
    u_itrp_ctl_model.stop();
    $display("t_refuse done");
  endtask : t_refuse
  task automatic t_read();
    setin(2'h2, 1'b0);
    wq.delete();
    u_itrp_ctl_model.start();
    wb(8'hd4, 1'b0);
    wb(8'hfe, 1'b0);
    u_itrp_ctl_model.start();
    wb(8'hd5, 1'b0);
    rb(1'b0, f(8'hfe));
    rb(1'b0, f(8'hff));
    rb(1'b1, f(8'h00));
    u_itrp_ctl_model.start();
    wb(8'hd4, 1'b0);
    wb(8'h07, 1'b0);
    wb(8'h99, 1'b0);
    u_itrp_ctl_model.stop();
    #200;
    chk("rw", {wq.size() == 1, wq[0].addr, wq[0].data}, {1'b1, 8'h07, 8'h99});
    chk("filt", filt_sel_q, 1'b0);
    $display("t_read done");
  endtask : t_read
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  // Runs take about 32 us; a hang ends the run here
  initial begin
    #400000;
    n_mismatch++;
    conclude();
  end
  initial begin
    srst = 1'b1;
    addr_sel = 2'h0;
    test_unlock = 1'b0;
    repeat (5) @(posedge clk);
    #1 srst = 1'b0;
    repeat (3) @(posedge clk);
    t_write();
    t_refuse();
    t_read();
    conclude();
  end
endmodule : itrp_target_tb
